/* File: logic/iop_pkg.sv */
package iop_pkg;

	// ****************************************
	// Register offsets in the I/O register space
	// ****************************************
	localparam logic [7:0] OFS_FUNC_A   = 8'h02;
	localparam logic [7:0] OFS_FUNC_B   = 8'h03;
	localparam logic [7:0] OFS_DIR_A    = 8'h04;
	localparam logic [7:0] OFS_DIR_B    = 8'h05;
	localparam logic [7:0] OFS_DIR_C    = 8'h06;
	localparam logic [7:0] OFS_DIR_D    = 8'h07;
	localparam logic [7:0] OFS_DRV_A    = 8'h08;
	localparam logic [7:0] OFS_DRV_B    = 8'h09;
	localparam logic [7:0] OFS_DRV_C    = 8'h0a;
	localparam logic [7:0] OFS_DRV_D    = 8'h0b;
	localparam logic [7:0] OFS_DOUT_A   = 8'h0c;
	localparam logic [7:0] OFS_DOUT_B   = 8'h0d;
	localparam logic [7:0] OFS_DOUT_C   = 8'h0e;
	localparam logic [7:0] OFS_DOUT_D   = 8'h0f;
	localparam logic [7:0] OFS_DIN_A    = 8'h10;
	localparam logic [7:0] OFS_DIN_B    = 8'h11;
	localparam logic [7:0] OFS_DIN_C    = 8'h12;
	localparam logic [7:0] OFS_DIN_D    = 8'h13;
	localparam logic [7:0] OFS_OEN_A    = 8'h14;
	localparam logic [7:0] OFS_OEN_B    = 8'h15;
	localparam logic [7:0] OFS_OEN_C    = 8'h16;
	localparam logic [7:0] OFS_OEN_D    = 8'h17;
	localparam logic [7:0] OFS_ICELL_A  = 8'h18;
	localparam logic [7:0] OFS_ICELL_B  = 8'h19;
	localparam logic [7:0] OFS_ICELL_C  = 8'h1a;
	localparam logic [7:0] OFS_SPACE    = 8'h1b;

	// ****************************************
	// Field positions, widths and reset values
	// ****************************************
	localparam int         PERIPH_BIT   = 7;
	localparam int         PORT_D_W     = 3;
	localparam logic [7:0] RST_CFG      = 8'h00;
	localparam logic [7:0] PORT_D_MASK  = 8'h07;
	localparam logic [7:0] OD_MASK_AB   = 8'hf0;
	localparam logic [7:0] OD_MASK_C    = 8'hff;

	// ****************************************
	// Bus types selecting the address-out map
	// ****************************************
	typedef enum logic [1:0] {
		IOP_BUS_MUX   = 2'b00,
		IOP_BUS_PAGE  = 2'b01,
		IOP_BUS_BURST = 2'b10,
		IOP_BUS_NMUX  = 2'b11
	} iop_bus_e;

	// ****************************************
	// Input cell modes
	// ****************************************
	typedef enum logic [1:0] {
		IOP_IC_DIRECT = 2'b00,
		IOP_IC_LATCH  = 2'b01,
		IOP_IC_EDGE   = 2'b10
	} iop_icell_e;

endpackage

/* File: logic/iop_input_cell.sv */
`timescale 1ns/1ps
module iop_input_cell #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [1:0]   cell_mode,
	input  wire logic         strobe_sel,
	input  wire logic         address_latch_strobe,
	input  wire logic         cell_clk_term,
	input  wire logic [W-1:0] pin_sync,
	output logic      [W-1:0] cell_out
);

	typedef struct packed {
		logic [W-1:0] held;
		logic         clk_q;
	} iop_icell_s;

	iop_icell_s st;
	iop_icell_s next_st;
	logic       cell_clk;

	assign cell_clk = strobe_sel ? address_latch_strobe : cell_clk_term;

	// ****************************************
	// Latch, edge register or direct path
	// ****************************************
	always_comb begin
		next_st       = st;
		next_st.clk_q = cell_clk;
		unique case (cell_mode)
			iop_pkg::IOP_IC_LATCH: begin
				if (cell_clk) begin
					next_st.held = pin_sync;
				end
			end
			iop_pkg::IOP_IC_EDGE: begin
				if (cell_clk && !st.clk_q) begin
					next_st.held = pin_sync;
				end
			end
			default: begin
				next_st.held = pin_sync;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cell_out = st.held;

endmodule // iop_input_cell

/* File: logic/iop_port_block.sv */
`timescale 1ns/1ps
// Operation
// - Driver enable is logic-array enable term ORed with direction bit.
// - Without enable term or logic output, direction bit alone sets the driver.
// - Ports A and B: function bit 0 is MCU I/O, 1 latched address out.
// - Direction bit 1 means output, 0 means input; inputs by default.
// - Function, direction and drive registers reset to zero.
// - MCU I/O outputs drive data-out; inputs read through data-in.
// - Address drives when function bit is one and enable term or direction bit is active.
// - Address nibble mapping follows bus type on ports A and B.
// - Input cells latch, register or pass pins; clocked by strobe or term; readable.
// - Decode-used inputs are high address inputs, capturable on the strobe.
// - Port A as non-multiplexed data bus disables its general I/O.
// - Space register bit 7 makes port A a bidirectional data buffer.
// - Peripheral buffer mode: port A floats unless a peripheral select is active during an MCU write cycle.
// - Logic outputs float with enable term inactive and direction bit cleared.
// - Ports C and D lack function select; MCU I/O unless logic assigns.
// - Config registers read and written by bus cycles at fixed offsets.
// - Register bit n controls pin n of its port.
// - Register modes change at run time; logic, data, address-in fixed by programming.
// - Test-port pins on C enabled by select input, configuration or enable.
// - Ports A, B, C eight pins; port D three, three direction bits.
// - Drive-select bit one makes capable pin open-drain; push-pull default.
// - Output-enable status reads 1 for driving, 0 for three-stated.
module iop_port_block #(
	parameter logic [1:0] BUS_TYPE = 2'b00,
	parameter logic       DATA_PORT_A = 1'b0,
	parameter logic       TEST_PORT_CFG = 1'b0,
	parameter logic [1:0] ICELL_MODE = 2'b01,
	parameter logic       ICELL_STROBE = 1'b1
) (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic [15:0] latched_addr,
	input  wire logic [7:0]  mcu_wdata,
	output logic      [7:0]  mcu_rdata,
	input  wire logic        mcu_write_cycle,
	input  wire logic        periph_select_a,
	input  wire logic        periph_select_b,
	input  wire logic        address_latch_strobe,
	input  wire logic        cell_clk_term,
	input  wire logic [26:0] oe_term,
	input  wire logic [26:0] logic_out_en,
	input  wire logic [26:0] logic_out,
	input  wire logic        test_port_select,
	input  wire logic        test_port_enable,
	output logic             test_port_active,
	input  wire logic [7:0]  pa_in,
	input  wire logic [7:0]  pb_in,
	input  wire logic [7:0]  pc_in,
	input  wire logic [2:0]  pd_in,
	output logic      [7:0]  pa_out,
	output logic      [7:0]  pa_oe,
	output logic      [7:0]  pb_out,
	output logic      [7:0]  pb_oe,
	output logic      [7:0]  pc_out,
	output logic      [7:0]  pc_oe,
	output logic      [2:0]  pd_out,
	output logic      [2:0]  pd_oe,
	output logic      [7:0]  icell_a,
	output logic      [7:0]  icell_b,
	output logic      [7:0]  icell_c
);

	typedef struct packed {
		logic [7:0]  func_a;
		logic [7:0]  func_b;
		logic [7:0]  dir_a;
		logic [7:0]  dir_b;
		logic [7:0]  dir_c;
		logic [2:0]  dir_d;
		logic [7:0]  drv_a;
		logic [7:0]  drv_b;
		logic [7:0]  drv_c;
		logic [2:0]  drv_d;
		logic [7:0]  dout_a;
		logic [7:0]  dout_b;
		logic [7:0]  dout_c;
		logic [2:0]  dout_d;
		logic [7:0]  space;
		logic [26:0] sync1;
		logic [26:0] sync2;
		logic        alsync1;
		logic        alsync2;
		logic [7:0]  rdata;
		logic [7:0]  mrdata;
		logic [26:0] pout;
		logic [26:0] poe;
		logic        tpa;
	} iop_port_s;

	iop_port_s   st;
	iop_port_s   next_st;
	logic [23:0] cell_abc;
	logic [7:0]  addr_a;
	logic [7:0]  addr_b;
	logic [7:0]  din_a;
	logic [7:0]  din_b;
	logic [7:0]  din_c;
	logic [2:0]  din_d;

	assign din_a = st.sync2[7:0];
	assign din_b = st.sync2[15:8];
	assign din_c = st.sync2[23:16];
	assign din_d = st.sync2[26:24];

	// ****************************************
	// Input cells on ports A, B and C
	// ****************************************
	iop_input_cell #(.W(24)) u_cell_abc (
		.mclk                 (mclk),
		.nrst                 (nrst),
		.cell_mode            (ICELL_MODE),
		.strobe_sel           (ICELL_STROBE),
		.address_latch_strobe (st.alsync2),
		.cell_clk_term        (cell_clk_term),
		.pin_sync             ({din_c, din_b, din_a}),
		.cell_out             (cell_abc)
	);

	// ****************************************
	// Latched address map by bus type
	// ****************************************
	always_comb begin
		addr_a = 8'h00;
		addr_b = 8'h00;
		unique case (iop_pkg::iop_bus_e'(BUS_TYPE))
			iop_pkg::IOP_BUS_MUX: begin
				addr_a = latched_addr[7:0];
				addr_b = latched_addr[7:0];
			end
			iop_pkg::IOP_BUS_PAGE: begin
				addr_b = latched_addr[15:8];
			end
			iop_pkg::IOP_BUS_BURST: begin
				addr_a = {latched_addr[7:4], 4'h0};
				addr_b = {4'h0, latched_addr[11:8]};
			end
			iop_pkg::IOP_BUS_NMUX: begin
				addr_b = latched_addr[7:0];
			end
		endcase
	end

	// ****************************************
	// Register file, pin mux and driver enables
	// ****************************************
	always_comb begin
		logic [7:0]  src_a;
		logic [7:0]  src_b;
		logic [26:0] en;
		logic [26:0] dir_all;
		logic [26:0] val;
		logic        periph;
		src_a   = 8'h00;
		src_b   = 8'h00;
		en      = '0;
		dir_all = '0;
		val     = '0;
		periph  = 1'b0;
		next_st = st;
		next_st.sync1   = {pd_in, pc_in, pb_in, pa_in};
		next_st.sync2   = st.sync1;
		next_st.alsync1 = address_latch_strobe;
		next_st.alsync2 = st.alsync1;
		if (reg_wr) begin
			unique case (reg_addr)
				iop_pkg::OFS_FUNC_A:  next_st.func_a = reg_wdata;
				iop_pkg::OFS_FUNC_B:  next_st.func_b = reg_wdata;
				iop_pkg::OFS_DIR_A:   next_st.dir_a  = reg_wdata;
				iop_pkg::OFS_DIR_B:   next_st.dir_b  = reg_wdata;
				iop_pkg::OFS_DIR_C:   next_st.dir_c  = reg_wdata;
				iop_pkg::OFS_DIR_D:   next_st.dir_d  = reg_wdata[iop_pkg::PORT_D_W-1:0];
				iop_pkg::OFS_DRV_A:   next_st.drv_a  = reg_wdata;
				iop_pkg::OFS_DRV_B:   next_st.drv_b  = reg_wdata;
				iop_pkg::OFS_DRV_C:   next_st.drv_c  = reg_wdata;
				iop_pkg::OFS_DRV_D:   next_st.drv_d  = reg_wdata[iop_pkg::PORT_D_W-1:0];
				iop_pkg::OFS_DOUT_A:  next_st.dout_a = reg_wdata;
				iop_pkg::OFS_DOUT_B:  next_st.dout_b = reg_wdata;
				iop_pkg::OFS_DOUT_C:  next_st.dout_c = reg_wdata;
				iop_pkg::OFS_DOUT_D:  next_st.dout_d = reg_wdata[iop_pkg::PORT_D_W-1:0];
				iop_pkg::OFS_SPACE:   next_st.space  = reg_wdata;
				default: ;
			endcase
		end

		if (reg_rd) begin
			unique case (reg_addr)
				iop_pkg::OFS_FUNC_A:  next_st.rdata = st.func_a;
				iop_pkg::OFS_FUNC_B:  next_st.rdata = st.func_b;
				iop_pkg::OFS_DIR_A:   next_st.rdata = st.dir_a;
				iop_pkg::OFS_DIR_B:   next_st.rdata = st.dir_b;
				iop_pkg::OFS_DIR_C:   next_st.rdata = st.dir_c;
				iop_pkg::OFS_DIR_D:   next_st.rdata = {5'h00, st.dir_d};
				iop_pkg::OFS_DRV_A:   next_st.rdata = st.drv_a;
				iop_pkg::OFS_DRV_B:   next_st.rdata = st.drv_b;
				iop_pkg::OFS_DRV_C:   next_st.rdata = st.drv_c;
				iop_pkg::OFS_DRV_D:   next_st.rdata = {5'h00, st.drv_d};
				iop_pkg::OFS_DOUT_A:  next_st.rdata = st.dout_a;
				iop_pkg::OFS_DOUT_B:  next_st.rdata = st.dout_b;
				iop_pkg::OFS_DOUT_C:  next_st.rdata = st.dout_c;
				iop_pkg::OFS_DOUT_D:  next_st.rdata = {5'h00, st.dout_d};
				iop_pkg::OFS_DIN_A:   next_st.rdata = din_a;
				iop_pkg::OFS_DIN_B:   next_st.rdata = din_b;
				iop_pkg::OFS_DIN_C:   next_st.rdata = din_c;
				iop_pkg::OFS_DIN_D:   next_st.rdata = {5'h00, din_d};
				iop_pkg::OFS_OEN_A:   next_st.rdata = st.poe[7:0];
				iop_pkg::OFS_OEN_B:   next_st.rdata = st.poe[15:8];
				iop_pkg::OFS_OEN_C:   next_st.rdata = st.poe[23:16];
				iop_pkg::OFS_OEN_D:   next_st.rdata = {5'h00, st.poe[26:24]};
				iop_pkg::OFS_ICELL_A: next_st.rdata = cell_abc[7:0];
				iop_pkg::OFS_ICELL_B: next_st.rdata = cell_abc[15:8];
				iop_pkg::OFS_ICELL_C: next_st.rdata = cell_abc[23:16];
				iop_pkg::OFS_SPACE:   next_st.rdata = st.space;
				default:              next_st.rdata = 8'h00;
			endcase
		end
		// Per-pin source select, bit n drives pin n
		for (int i = 0; i < 8; i++) begin
			src_a[i] = st.func_a[i] ? addr_a[i] : st.dout_a[i];
			src_b[i] = st.func_b[i] ? addr_b[i] : st.dout_b[i];
		end
		dir_all = {st.dir_d, st.dir_c, st.dir_b, st.dir_a};
		val     = {st.dout_d, st.dout_c, src_b, src_a};
		for (int i = 0; i < 27; i++) begin
			en[i] = oe_term[i] | dir_all[i];
			if (logic_out_en[i]) begin
				val[i] = logic_out[i];
			end
		end
		// Port A overrides: data port and peripheral buffer
		periph = st.space[iop_pkg::PERIPH_BIT];
		if (DATA_PORT_A) begin
			en[7:0]  = {8{!mcu_write_cycle}} ^ 8'hff;
			val[7:0] = mcu_wdata;
		end else if (periph) begin
			en[7:0]  = {8{(periph_select_a | periph_select_b) & mcu_write_cycle}};
			val[7:0] = mcu_wdata;
		end
		// Open drain: drive only lows on capable pins
		for (int i = 0; i < 8; i++) begin
			if (st.drv_a[i] & iop_pkg::OD_MASK_AB[i] & val[i]) en[i] = 1'b0;
			if (st.drv_b[i] & iop_pkg::OD_MASK_AB[i] & val[8+i]) en[8+i] = 1'b0;
			if (st.drv_c[i] & iop_pkg::OD_MASK_C[i] & val[16+i]) en[16+i] = 1'b0;
		end
		next_st.tpa = test_port_select | TEST_PORT_CFG | test_port_enable;
		next_st.pout = val;
		next_st.poe  = en;
		next_st.mrdata = DATA_PORT_A ? din_a :
			((periph && (periph_select_a | periph_select_b)) ? din_a : 8'h00);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata        = st.rdata;
	assign mcu_rdata        = st.mrdata;
	assign test_port_active = st.tpa;
	assign pa_out  = st.pout[7:0];
	assign pb_out  = st.pout[15:8];
	assign pc_out  = st.pout[23:16];
	assign pd_out  = st.pout[26:24];
	assign pa_oe   = st.poe[7:0];
	assign pb_oe   = st.poe[15:8];
	assign pc_oe   = st.poe[23:16];
	assign pd_oe   = st.poe[26:24];
	assign icell_a = cell_abc[7:0];
	assign icell_b = cell_abc[15:8];
	assign icell_c = cell_abc[23:16];

	// ****************************************
	// Assertions
	// ****************************************
	property p_reset_zero;
		@(posedge mclk) $rose(nrst) |-> (st.dir_a == 8'h00 && st.func_a == 8'h00 && st.drv_c == 8'h00);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");
	property p_dir_oe;
		@(posedge mclk) disable iff (!nrst)
		(!DATA_PORT_A && !st.space[7] && st.dir_c[0] && !st.drv_c[0]) |=> pc_oe[0];
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("direction did not enable driver");
	property p_term_oe;
		@(posedge mclk) disable iff (!nrst)
		(oe_term[24] || st.dir_d[0]) |=> pd_oe[0];
	endproperty
	a_term_oe: assert property (p_term_oe) else $error("enable term ignored");
	property p_float;
		@(posedge mclk) disable iff (!nrst)
		(!oe_term[25] && !st.dir_d[1]) |=> !pd_oe[1];
	endproperty
	a_float: assert property (p_float) else $error("driver on without cause");
	sequence s_wr_dir_b;
		reg_wr && reg_addr == iop_pkg::OFS_DIR_B;
	endsequence
	property p_write_next;
		@(posedge mclk) disable iff (!nrst)
		s_wr_dir_b ##1 1'b1 |-> st.dir_b == $past(reg_wdata);
	endproperty
	a_write_next: assert property (p_write_next) else $error("write not applied next cycle");
	property p_readback;
		@(posedge mclk) disable iff (!nrst)
		(reg_rd && reg_addr == iop_pkg::OFS_DIR_D) |=> reg_rdata[7:3] == 5'h00;
	endproperty
	a_readback: assert property (p_readback) else $error("port D upper bits not zero");
	property p_periph_float;
		@(posedge mclk) disable iff (!nrst)
		(!DATA_PORT_A && st.space[7] && !periph_select_a && !periph_select_b) |=> pa_oe == 8'h00;
	endproperty
	a_periph_float: assert property (p_periph_float) else $error("port A driven without select");
	property p_addr_out;
		@(posedge mclk) disable iff (!nrst)
		(BUS_TYPE == 2'b00 && st.func_b[2] && !logic_out_en[10] && !DATA_PORT_A)
			|=> pb_out[2] == $past(latched_addr[2]);
	endproperty
	a_addr_out: assert property (p_addr_out) else $error("address not on port B");
	property p_test_port;
		@(posedge mclk) disable iff (!nrst)
		test_port_select |=> test_port_active;
	endproperty
	a_test_port: assert property (p_test_port) else $error("test port not enabled");

endmodule // iop_port_block

/* File: sim/iop_pin_model.sv */
`timescale 1ns/1ps
module iop_pin_model (
	input  wire logic [7:0]  pa_out,
	input  wire logic [7:0]  pa_oe,
	input  wire logic [7:0]  pb_out,
	input  wire logic [7:0]  pb_oe,
	input  wire logic [7:0]  pc_out,
	input  wire logic [7:0]  pc_oe,
	input  wire logic [2:0]  pd_out,
	input  wire logic [2:0]  pd_oe,
	input  wire logic [26:0] ext_val,
	input  wire logic [26:0] ext_en,
	output logic      [7:0]  pa_in,
	output logic      [7:0]  pb_in,
	output logic      [7:0]  pc_in,
	output logic      [2:0]  pd_in
);
	// ****************************************
	// Pin level: own driver, else board source, else pull-up
	// ****************************************
	logic [26:0] oe_all;
	logic [26:0] out_all;
	logic [26:0] pin_all;
	assign oe_all  = {pd_oe, pc_oe, pb_oe, pa_oe};
	assign out_all = {pd_out, pc_out, pb_out, pa_out};
	assign pin_all = (oe_all & out_all) | (~oe_all & ext_en & ext_val) | (~oe_all & ~ext_en);
	assign pa_in   = pin_all[7:0];
	assign pb_in   = pin_all[15:8];
	assign pc_in   = pin_all[23:16];
	assign pd_in   = pin_all[26:24];
endmodule // iop_pin_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb_top;
	logic        mclk, nrst, reg_wr, reg_rd, mcu_write_cycle, periph_select_a, periph_select_b;
	logic        address_latch_strobe, test_port_select, test_port_enable;
	logic [7:0]  reg_addr, reg_wdata, mcu_wdata, rdv;
	logic [15:0] latched_addr;
	logic [26:0] oe_term, logic_out_en, logic_out, ext_val, ext_en;
	logic [7:0]  reg_rdata, mcu_rdata, pa_in, pb_in, pc_in, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
	logic [7:0]  icell_a, icell_b, icell_c;
	logic [2:0]  pd_in, pd_out, pd_oe;
	logic        test_port_active;
	int          mismatches = 0;
	int          checks = 0;
	int          cycles = 0;

	iop_port_block dut_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .latched_addr(latched_addr), .mcu_wdata(mcu_wdata),
		.mcu_rdata(mcu_rdata), .mcu_write_cycle(mcu_write_cycle), .periph_select_a(periph_select_a),
		.periph_select_b(periph_select_b), .address_latch_strobe(address_latch_strobe), .cell_clk_term(1'b0),
		.oe_term(oe_term), .logic_out_en(logic_out_en), .logic_out(logic_out),
		.test_port_select(test_port_select), .test_port_enable(test_port_enable),
		.test_port_active(test_port_active), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .pd_in(pd_in),
		.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe),
		.pd_out(pd_out), .pd_oe(pd_oe), .icell_a(icell_a), .icell_b(icell_b), .icell_c(icell_c));

	iop_pin_model pins_u (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out),
		.pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe), .ext_val(ext_val), .ext_en(ext_en), .pa_in(pa_in),
		.pb_in(pb_in), .pc_in(pc_in), .pd_in(pd_in));

	// ****************************************
	// Bus cycles and helpers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		rdv = reg_rdata;
		`CHK(nm, e, rdv)
	endtask

	task automatic settle;
		repeat (4) @(negedge mclk);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		for (int i = iop_pkg::OFS_FUNC_A; i <= iop_pkg::OFS_DRV_D; i++) rchk("cfg_rst", 8'(i), iop_pkg::RST_CFG);
		`CHK("oe_rst", 27'h0, {pd_oe, pc_oe, pb_oe, pa_oe})
	endtask

	task automatic t_regs;
		wr(iop_pkg::OFS_DIR_D, 8'hff);
		rchk("dir_d", iop_pkg::OFS_DIR_D, 8'h07);
		wr(iop_pkg::OFS_DRV_D, 8'hff);
		rchk("drv_d", iop_pkg::OFS_DRV_D, 8'h07);
		wr(iop_pkg::OFS_DIR_A, 8'ha5);
		rchk("dir_a", iop_pkg::OFS_DIR_A, 8'ha5);
		wr(8'hf0, 8'h5a);
		rchk("unmapped", 8'hf0, 8'h00);
		wr(iop_pkg::OFS_DIR_D, 8'h00);
		wr(iop_pkg::OFS_DRV_D, 8'h00);
		wr(iop_pkg::OFS_DIR_A, 8'h00);
	endtask

	task automatic t_mcu_io;
		wr(iop_pkg::OFS_DOUT_B, 8'h3c);
		wr(iop_pkg::OFS_DIR_B, 8'h0f);
		settle();
		`CHK("pb_oe", 8'h0f, pb_oe)
		`CHK("pb_out", 8'h0c, pb_out & 8'h0f)
		rchk("oen_b", iop_pkg::OFS_OEN_B, 8'h0f);
		wr(iop_pkg::OFS_DIR_B, 8'h00);
		settle();
		`CHK("pb_oe_off", 8'h00, pb_oe)
		wr(iop_pkg::OFS_DOUT_D, 8'hfd);
		wr(iop_pkg::OFS_DIR_D, 8'h05);
		settle();
		`CHK("pd_oe", 3'h5, pd_oe)
		`CHK("pd_out", 3'h5, pd_out)
		rchk("dout_d", iop_pkg::OFS_DOUT_D, 8'h05);
		rchk("oen_d", iop_pkg::OFS_OEN_D, 8'h05);
		wr(iop_pkg::OFS_DIR_D, 8'h00);
	endtask

	task automatic t_oe_term;
		ext_en[23:16] = 8'hff;
		ext_val[23:16] = 8'h5a;
		settle();
		rchk("din_c", iop_pkg::OFS_DIN_C, 8'h5a);
		ext_en = '0;
		oe_term[23:16] = 8'h81;
		settle();
		`CHK("pc_oe_term", 8'h81, pc_oe)
		wr(iop_pkg::OFS_DIR_C, 8'h18);
		settle();
		`CHK("pc_oe_or", 8'h99, pc_oe)
		oe_term = '0;
		settle();
		`CHK("pc_oe_dir", 8'h18, pc_oe)
		wr(iop_pkg::OFS_DIR_C, 8'h00);
	endtask

	task automatic t_addr_out;
		latched_addr = 16'h1234;
		wr(iop_pkg::OFS_FUNC_A, 8'hff);
		settle();
		`CHK("pa_oe_func", 8'h00, pa_oe)
		wr(iop_pkg::OFS_DIR_A, 8'hff);
		settle();
		`CHK("pa_oe_addr", 8'hff, pa_oe)
		`CHK("pa_addr", 8'h34, pa_out)
		latched_addr = 16'h9abc;
		settle();
		`CHK("pa_addr2", 8'hbc, pa_out)
		wr(iop_pkg::OFS_FUNC_A, 8'h00);
		wr(iop_pkg::OFS_DOUT_A, 8'h0f);
		settle();
		`CHK("pa_mcu", 8'h0f, pa_out)
		wr(iop_pkg::OFS_DIR_A, 8'h00);
	endtask

	task automatic t_periph;
		wr(iop_pkg::OFS_SPACE, 8'h80);
		mcu_write_cycle = 1'b1;
		mcu_wdata = 8'hc3;
		settle();
		`CHK("per_idle", 8'h00, pa_oe)
		periph_select_b = 1'b1;
		settle();
		`CHK("per_oe", 8'hff, pa_oe)
		`CHK("per_out", 8'hc3, pa_out)
		mcu_write_cycle = 1'b0;
		ext_en[7:0] = 8'hff;
		ext_val[7:0] = 8'h69;
		settle();
		`CHK("per_rd", 8'h69, mcu_rdata)
		periph_select_b = 1'b0;
		settle();
		`CHK("per_rd0", 8'h00, mcu_rdata)
		ext_en = '0;
		wr(iop_pkg::OFS_SPACE, 8'h00);
	endtask

	task automatic t_logic;
		logic_out_en[8] = 1'b1;
		logic_out[8] = 1'b1;
		oe_term[8] = 1'b1;
		settle();
		`CHK("lg_oe", 1'b1, pb_oe[0])
		`CHK("lg_out", 1'b1, pb_out[0])
		oe_term[8] = 1'b0;
		settle();
		`CHK("lg_off", 1'b0, pb_oe[0])
		wr(iop_pkg::OFS_DIR_B, 8'h01);
		settle();
		`CHK("lg_dir", 1'b1, pb_oe[0])
		wr(iop_pkg::OFS_DIR_B, 8'h00);
		logic_out_en = '0;
	endtask

	task automatic t_open_drain;
		wr(iop_pkg::OFS_DOUT_C, 8'h01);
		wr(iop_pkg::OFS_DIR_C, 8'h01);
		settle();
		`CHK("pp_oe", 8'h01, pc_oe)
		wr(iop_pkg::OFS_DRV_C, 8'h01);
		settle();
		`CHK("od_high", 8'h00, pc_oe)
		wr(iop_pkg::OFS_DOUT_C, 8'h00);
		settle();
		`CHK("od_low", 8'h01, pc_oe)
		`CHK("od_val", 1'b0, pc_out[0])
		wr(iop_pkg::OFS_DIR_C, 8'h00);
		wr(iop_pkg::OFS_DRV_C, 8'h00);
	endtask

	task automatic t_icell;
		ext_en[15:8] = 8'hff;
		ext_val[15:8] = 8'h9c;
		address_latch_strobe = 1'b1;
		settle();
		address_latch_strobe = 1'b0;
		settle();
		ext_val[15:8] = 8'h00;
		settle();
		`CHK("icell_b", 8'h9c, icell_b)
		`CHK("icell_a", 8'hff, icell_a)
		`CHK("icell_c", 8'hff, icell_c)
		rchk("icell_rd", iop_pkg::OFS_ICELL_B, 8'h9c);
		ext_en = '0;
	endtask

	task automatic t_test_port;
		test_port_select = 1'b1;
		settle();
		`CHK("tp_sel", 1'b1, test_port_active)
		test_port_select = 1'b0;
		test_port_enable = 1'b1;
		settle();
		`CHK("tp_en", 1'b1, test_port_active)
		test_port_enable = 1'b0;
		settle();
		`CHK("tp_off", 1'b0, test_port_active)
	endtask

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		{nrst, reg_wr, reg_rd, mcu_write_cycle, periph_select_a, periph_select_b} = '0;
		{address_latch_strobe, test_port_select, test_port_enable} = '0;
		{reg_addr, reg_wdata, mcu_wdata, latched_addr} = '0;
		{oe_term, logic_out_en, logic_out, ext_val, ext_en} = '0;
		repeat (8) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		t_reset();
		t_regs();
		t_mcu_io();
		t_oe_term();
		t_addr_out();
		t_periph();
		t_logic();
		t_open_drain();
		t_icell();
		t_test_port();
		complete_run();
	end
endmodule // tb_top
